// ---- src/p1cfg_defines.svh ----
// Offsets, field positions and reset values of the port-1 upper pin block
`ifndef P1CFG_DEFINES_SVH
`define P1CFG_DEFINES_SVH

// Register indices; the byte address is four times the index
`define P1CFG_IDX_PIN4      8'h11
`define P1CFG_IDX_PIN5      8'h12
`define P1CFG_IDX_PIN6      8'h13
`define P1CFG_IDX_PIN7      8'h14
// Block-local registers: port-1 data bits 7..4, SPI mode/enable, status
`define P1CFG_IDX_DATA      8'h20
`define P1CFG_IDX_SPICTL    8'h21
`define P1CFG_IDX_STATUS    8'h22

`define P1CFG_BIT_OE        0
`define P1CFG_BIT_PULLUP    1
`define P1CFG_BIT_ODRAIN    2
`define P1CFG_BIT_HSINK     3
`define P1CFG_BIT_ACTLOW    5
`define P1CFG_BIT_INTEN     6
`define P1CFG_BIT_SPIUSE    7

// Writable masks: bit 4 reserved everywhere, bit 7 reserved on pin 7
`define P1CFG_MASK_SPIPIN   8'hEF
`define P1CFG_MASK_PIN7     8'h6F
`define P1CFG_RESET         8'h00

`define P1CFG_MODE_MASTER   2'h1
`define P1CFG_MODE_SLAVE    2'h2

`endif

// ---- src/p1cfg_pkg.sv ----
// Types of the port-1 upper pin configuration block
package p1cfg_pkg;
  typedef enum logic [1:0] {
    P1CFG_IDLE,
    P1CFG_WRITE,
    P1CFG_READ
  } p1cfg_phase_t;

  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic [3:0]      data;
    logic            spi_en;
    logic [1:0]      mode;
    logic [31:0]     rdata;
    logic [7:0]      addr;
    p1cfg_phase_t    phase;
  } p1cfg_state_t;
endpackage

// ---- src/p1cfg_pin.sv ----
// One pin's output mux and interrupt level detect
`timescale 1ns/1ns
`include "p1cfg_defines.svh"
module p1cfg_pin
  import p1cfg_pkg::*;
(
  // Configuration
  input  wire logic [7:0] cfg,
  input  wire logic       data_bit,
  input  wire logic       spi_sel,
  // SPI side
  input  wire logic       spi_out,
  input  wire logic       spi_dir_out,
  // Pin
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe_n,
  output logic            pin_pullup,
  output logic            pin_hsink,
  output logic            irq_level
);
  logic drive_out;
  logic val;

  always_comb begin
    if (spi_sel) begin
      drive_out = spi_dir_out;
      val       = spi_out;
    end else begin
      drive_out = cfg[`P1CFG_BIT_OE];
      val       = data_bit;
    end
    // Open drain only pulls low, in either use
    if (cfg[`P1CFG_BIT_ODRAIN] && val)
      drive_out = 1'b0;
    pin_oe_n   = ~drive_out;
    pin_out    = val;
    pin_pullup = cfg[`P1CFG_BIT_PULLUP];
    pin_hsink  = cfg[`P1CFG_BIT_HSINK];
    // Level interrupt, polarity from active-low bit
    irq_level  = cfg[`P1CFG_BIT_INTEN] &
                 (pin_in ^ cfg[`P1CFG_BIT_ACTLOW]);
  end
endmodule // p1cfg_pin

// ---- src/p1cfg_top.sv ----
// AHB-Lite register block for port-1 pins four to seven
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "p1cfg_defines.svh"
// Functional notes
// - Three 8-bit identical config registers for pins four to six.
// - Pins four to six always use TTL input thresholds.
// - SPI enabled and SPI-use set: SPI drives enable and value.
// - Otherwise the pin follows its enable bit and data bit.
// - Interrupt, sink, open-drain, pull-up settings act in both uses.
// - Bit 7 clear is GPIO, set hands output to SPI.
// - In master or slave mode SPI sets select/data pin direction.
// - Serial-clock pin direction always comes from its enable bit.
// - Pin seven register; bits 7 and 4 reserved.
// - Pin seven always uses a TTL threshold.
module p1cfg_top
  import p1cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // SPI engine side: pins 3,5,6 outputs and directions, pin 4 output
  input  wire logic        spi_select_out,
  input  wire logic        spi_sclk_out,
  input  wire logic        spi_mosi_out,
  input  wire logic        spi_miso_out,
  input  wire logic        spi_mosi_dir_out,
  input  wire logic        spi_miso_dir_out,
  input  wire logic        spi_select_dir_out,
  output logic             spi_enable,
  output logic [1:0]       spi_mode,
  // Select pin controls for pin three
  output logic             port1_pin3_select_auto,
  output logic             port1_pin3_select_oe_n,
  // Pins four to seven
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe_n,
  output logic [3:0]       pin_pullup,
  output logic [3:0]       pin_hsink,
  output logic [3:0]       pin_ttl,
  // Port interrupt request
  output logic             port_irq
);
  // ****************************************
  // Register state
  // ****************************************
  p1cfg_state_t s_q;
  p1cfg_state_t s_d;
  logic [3:0]   irq_lvl;
  logic [3:0]   spi_sel;
  logic [3:0]   spi_o;
  logic [3:0]   spi_dir;
  logic         comm_mode;

  // Pin seven also masks bit 7
  function automatic logic [7:0] reg_mask(input logic [7:0] idx);
    case (idx)
      `P1CFG_IDX_PIN7: reg_mask = `P1CFG_MASK_PIN7;
      default:         reg_mask = `P1CFG_MASK_SPIPIN;
    endcase
  endfunction

  function automatic logic is_cfg(input logic [7:0] idx);
    is_cfg = (idx >= `P1CFG_IDX_PIN4) && (idx <= `P1CFG_IDX_PIN7);
  endfunction

  logic       take;
  logic [7:0] idx_a;
  logic [7:0] wr_val;
  logic [1:0] slot;
  assign take  = hsel & hready & htrans[1];
  assign idx_a = haddr[9:2];
  assign wr_val = hwdata[7:0];
  assign slot  = 2'(s_q.addr - `P1CFG_IDX_PIN4);

  always_comb begin
    s_d = s_q;
    if (s_q.phase == P1CFG_WRITE) begin
      if (is_cfg(s_q.addr)) begin
        // Identical layout, reserved bit held zero
        s_d.cfg[slot] = wr_val & reg_mask(s_q.addr);
      end else if (s_q.addr == `P1CFG_IDX_DATA) begin
        s_d.data = wr_val[3:0];
      end else if (s_q.addr == `P1CFG_IDX_SPICTL) begin
        s_d.spi_en = wr_val[0];
        s_d.mode   = wr_val[2:1];
      end
    end
    if (take) begin
      s_d.addr  = idx_a;
      s_d.phase = hwrite ? P1CFG_WRITE : P1CFG_READ;
      s_d.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (idx_a)
          `P1CFG_IDX_PIN4,
          `P1CFG_IDX_PIN5,
          `P1CFG_IDX_PIN6,
          `P1CFG_IDX_PIN7:
            s_d.rdata[7:0] = s_d.cfg[2'(idx_a - `P1CFG_IDX_PIN4)];
          `P1CFG_IDX_DATA:   s_d.rdata[3:0] = s_d.data;
          `P1CFG_IDX_SPICTL: s_d.rdata[2:0] = {s_d.mode, s_d.spi_en};
          `P1CFG_IDX_STATUS: s_d.rdata[7:0] = {irq_lvl, pin_in};
          default:           s_d.rdata = 32'h0000_0000;
        endcase
      end
    end else begin
      s_d.phase = P1CFG_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states, always OKAY; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_q.rdata;

  // ****************************************
  // Pin muxing
  // ****************************************
  assign spi_enable = s_q.spi_en;
  assign spi_mode   = s_q.mode;
  assign comm_mode  = (s_q.mode == `P1CFG_MODE_MASTER) ||
                      (s_q.mode == `P1CFG_MODE_SLAVE);
  // Select direction set by SPI logic in comm modes
  assign port1_pin3_select_auto = s_q.spi_en & comm_mode;
  assign port1_pin3_select_oe_n = ~spi_select_dir_out;

  assign spi_o = {1'b0, spi_miso_out, spi_mosi_out, spi_sclk_out};
  // Clock pin direction from its own enable bit
  assign spi_dir[0] = s_q.cfg[0][`P1CFG_BIT_OE];
  // Data pins follow SPI direction only in comm modes
  assign spi_dir[1] = comm_mode ? spi_mosi_dir_out
                                : s_q.cfg[1][`P1CFG_BIT_OE];
  assign spi_dir[2] = comm_mode ? spi_miso_dir_out
                                : s_q.cfg[2][`P1CFG_BIT_OE];
  assign spi_dir[3] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      // Bit 7 selects SPI use only while SPI is enabled
      assign spi_sel[g] = s_q.spi_en & s_q.cfg[g][`P1CFG_BIT_SPIUSE];
      p1cfg_pin u_pin (
        .cfg         (s_q.cfg[g]),
        .data_bit    (s_q.data[g]),
        .spi_sel     (spi_sel[g]),
        .spi_out     (spi_o[g]),
        .spi_dir_out (spi_dir[g]),
        .pin_in      (pin_in[g]),
        .pin_out     (pin_out[g]),
        .pin_oe_n    (pin_oe_n[g]),
        .pin_pullup  (pin_pullup[g]),
        .pin_hsink   (pin_hsink[g]),
        .irq_level   (irq_lvl[g])
      );
    end
  endgenerate

  assign pin_ttl  = 4'hF;
  // Port interrupt is OR of enabled pin levels
  assign port_irq = |irq_lvl;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_reserved_bits: assert property (
    !s_q.cfg[3][7] && !s_q.cfg[3][4] && !s_q.cfg[0][4])
    else $error("reserved config bit set");
  a_ttl_fixed: assert property (
    pin_ttl == 4'hF) else $error("threshold not TTL");
  a_sclk_dir: assert property (
    (!s_q.cfg[0][`P1CFG_BIT_ODRAIN] || !pin_out[0]) |->
    (pin_oe_n[0] == !s_q.cfg[0][`P1CFG_BIT_OE]))
    else $error("clock pin direction not from enable bit");
  a_gpio_drive: assert property (
    (!spi_sel[3] && !s_q.cfg[3][`P1CFG_BIT_ODRAIN]) |->
    (pin_out[3] == s_q.data[3] &&
     pin_oe_n[3] == !s_q.cfg[3][`P1CFG_BIT_OE]))
    else $error("gpio drive mismatch");
  a_spi_drive: assert property (
    spi_sel[1] |-> pin_out[1] == spi_mosi_out)
    else $error("spi drive mismatch");
  a_write_cfg: assert property (
    (take && hwrite && idx_a == `P1CFG_IDX_PIN5) ##1 1'b1 |=>
    s_q.cfg[1] == ($past(hwdata[7:0]) & `P1CFG_MASK_SPIPIN))
    else $error("pin5 config write lost");
  a_irq_level: assert property (
    (s_q.cfg[2][`P1CFG_BIT_INTEN] &&
     pin_in[2] != s_q.cfg[2][`P1CFG_BIT_ACTLOW]) |-> port_irq)
    else $error("interrupt level missed");
  a_opendrain: assert property (
    (s_q.cfg[1][`P1CFG_BIT_ODRAIN] && pin_out[1]) |-> pin_oe_n[1])
    else $error("open drain drove high");
  a_gpio_when_clear: assert property (
    !s_q.cfg[2][`P1CFG_BIT_SPIUSE] |-> !spi_sel[2])
    else $error("spi took gpio pin");

  c_spi_pin: cover property (spi_sel[1] && comm_mode);
  c_irq: cover property (port_irq);
  c_read: cover property (take && !hwrite && idx_a == `P1CFG_IDX_PIN7);
endmodule // p1cfg_top

// ---- tb/p1cfg_peer.sv ----
// Model of the SPI engine and the pad wires beside the pin block
`timescale 1ns/1ns
module p1cfg_peer (
  // Clock and block state
  input  wire logic       core_clk,
  input  wire logic       spi_enable,
  input  wire logic [1:0] spi_mode,
  // Pad side
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic [3:0] pin_pullup,
  input  wire logic [3:0] ext_level,
  output logic      [3:0] pin_in,
  // SPI engine values and directions
  output logic            spi_select_out,
  output logic            spi_sclk_out,
  output logic            spi_mosi_out,
  output logic            spi_miso_out,
  output logic            spi_mosi_dir_out,
  output logic            spi_miso_dir_out,
  output logic            spi_select_dir_out
);
  logic [1:0] cnt_q = 2'h0;
  logic       master;
  logic       slave;
  always @(posedge core_clk) begin
    cnt_q <= cnt_q + 2'h1;
  end
  assign master = spi_enable & (spi_mode == 2'h1);
  assign slave  = spi_enable & (spi_mode == 2'h2);
  // Clock stands still while the engine is off
  assign spi_sclk_out       = spi_enable & cnt_q[0];
  assign spi_mosi_out       = cnt_q[1];
  assign spi_miso_out       = cnt_q[1] ^ ~cnt_q[0];
  assign spi_select_out     = ~master;
  assign spi_mosi_dir_out   = master;
  assign spi_miso_dir_out   = slave;
  assign spi_select_dir_out = master;
  // Released pads show the pull-up or the outside driver, never the old value
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pullup | ext_level));
endmodule // p1cfg_peer

// ---- tb/testbench.sv ----
// Self-checking bench for the port-1 upper pin block
`timescale 1ns/1ns
`include "p1cfg_defines.svh"
module testbench;
  // Bench-driven inputs
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [3:0]  ext_level = 4'h0;
  // Design outputs and peer wires
  wire         hready, hreadyout, hresp, spi_enable, port_irq;
  wire  [31:0] hrdata;
  wire  [1:0]  spi_mode;
  wire         spi_select_out, spi_sclk_out, spi_mosi_out, spi_miso_out;
  wire         spi_mosi_dir_out, spi_miso_dir_out, spi_select_dir_out;
  wire         port1_pin3_select_auto, port1_pin3_select_oe_n;
  wire  [3:0]  pin_in, pin_out, pin_oe_n, pin_pullup, pin_hsink, pin_ttl;
  int          bad_count = 0;
  int          check_count = 0;
  logic [31:0] rd;
  logic [7:0]  cf [4];
  logic        en;
  logic        e;
  logic [1:0]  md;
  logic [3:0]  d;

  always #5 core_clk = ~core_clk;
  assign hready = hreadyout;

  p1cfg_top dut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .spi_select_out,
    .spi_sclk_out, .spi_mosi_out, .spi_miso_out, .spi_mosi_dir_out,
    .spi_miso_dir_out, .spi_select_dir_out, .spi_enable, .spi_mode,
    .port1_pin3_select_auto, .port1_pin3_select_oe_n, .pin_in, .pin_out,
    .pin_oe_n, .pin_pullup, .pin_hsink, .pin_ttl, .port_irq);
  p1cfg_peer peer (.core_clk, .spi_enable, .spi_mode, .pin_out, .pin_oe_n,
    .pin_pullup, .ext_level, .pin_in, .spi_select_out, .spi_sclk_out,
    .spi_mosi_out, .spi_miso_out, .spi_mosi_dir_out, .spi_miso_dir_out,
    .spi_select_dir_out);

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  function automatic logic [7:0] masked(input logic [7:0] idx, v);
    return v & ((idx == `P1CFG_IDX_PIN7) ? `P1CFG_MASK_PIN7
                                          : `P1CFG_MASK_SPIPIN);
  endfunction

  task automatic chk(input string n, input logic [31:0] x, s);
    check_count++;
    if (s !== x) begin
      $display("Error %s expected %h seen %h", n, x, s);
      bad_count++;
    end
  endtask

  // Single word transfer; waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] idx, wd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic pin_chk(input int i);
    logic       s;
    logic       eo;
    logic       eoe;
    logic [3:0] so;
    logic [3:0] sd;
    so  = {1'b0, spi_miso_out, spi_mosi_out, spi_sclk_out};
    sd  = {1'b0, spi_miso_dir_out, spi_mosi_dir_out, 1'b0};
    s   = en && cf[i][7] && i < 3;
    eo  = s ? so[i] : d[i];
    eoe = !((s && i > 0 && md inside {2'h1, 2'h2}) ? sd[i] : cf[i][0]);
    eoe = eoe | (cf[i][2] & eo);
    chk("pin oe_n", 32'(eoe), 32'(pin_oe_n[i]));
    if (!eoe) chk("pin out", 32'(eo), 32'(pin_out[i]));
    chk("pull-up", 32'(cf[i][1]), 32'(pin_pullup[i]));
    chk("high sink", 32'(cf[i][3]), 32'(pin_hsink[i]));
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rd = $urandom(47);
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, 8'h11 + 8'(i), 8'h0);
      chk("cfg reset", 32'h0, rd);
      cf[0] = 8'($urandom);
      ahb(1'b1, 8'h11 + 8'(i), cf[0]);
      ahb(1'b0, 8'h11 + 8'(i), 8'h0);
      chk("cfg mask", 32'(masked(8'h11 + 8'(i), cf[0])), rd);
    end
    ahb(1'b1, 8'h30, 8'hFF);
    ahb(1'b0, 8'h30, 8'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, `P1CFG_IDX_DATA, 8'h5A);
    ahb(1'b0, `P1CFG_IDX_DATA, 8'h0);
    chk("data reg", 32'hA, rd);
    ahb(1'b1, `P1CFG_IDX_SPICTL, 8'hFD);
    ahb(1'b0, `P1CFG_IDX_SPICTL, 8'h0);
    chk("spi ctl reg", 32'h5, rd);
    chk("ttl", 32'hF, 32'(pin_ttl));
    $display("test registers done");
    for (int n = 0; n < 40; n++) begin
      en = 1'($urandom);
      md = 2'($urandom);
      d  = 4'($urandom);
      ext_level <= 4'($urandom);
      for (int i = 0; i < 4; i++)
        cf[i] = masked(8'h11 + 8'(i), 8'($urandom));
      // clock pin out for master, in for slave
      if (en && md == 2'h1) cf[0][0] = 1'b1;
      if (en && md == 2'h2) cf[0][0] = 1'b0;
      for (int i = 0; i < 4; i++)
        ahb(1'b1, 8'h11 + 8'(i), cf[i]);
      ahb(1'b1, `P1CFG_IDX_DATA, {4'h0, d});
      ahb(1'b1, `P1CFG_IDX_SPICTL, {5'h0, md, en});
      repeat (3) begin
        @(negedge core_clk);
        for (int i = 0; i < 4; i++)
          pin_chk(i);
        e = 1'b0;
        for (int i = 0; i < 4; i++)
          e = e | (cf[i][6] & (pin_in[i] ^ cf[i][5]));
        chk("irq", 32'(e), 32'(port_irq));
        chk("select auto", 32'(en && md inside {2'h1, 2'h2}),
            32'(port1_pin3_select_auto));
        chk("spi ctl", 32'({md, en}),
            32'({spi_mode, spi_enable}));
        chk("select oe_n", 32'(!spi_select_dir_out),
            32'(port1_pin3_select_oe_n));
      end
    end
    $display("test pins done");
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("oe_n in reset", 32'hF, 32'(pin_oe_n));
    chk("irq in reset", 32'h0, 32'(port_irq));
    rstn <= 1'b1;
    ahb(1'b0, `P1CFG_IDX_PIN6, 8'h0);
    chk("cfg second reset", 32'h0, rd);
    chk("spi off", 32'h0, 32'(spi_enable));
    ahb(1'b0, `P1CFG_IDX_STATUS, 8'h0);
    chk("status", 32'({4'h0, ext_level}), rd);
    $display("test reset done");
    test_done();
  end
endmodule // testbench
